/* File: hdl/tfg_top.sv */
/*
  Test frame generator with its register file and transmit source switch.
  Assumes all inputs come from logic on mclk_in, one byte per enabled cycle
  toward the PHY transmitter, and the subsystem mask bit held outside.
*/
// Functional notes
// (RL1) Enabled generator replaces MAC as PHY source.
// (RL2) Restart bit restarts generation, self clears.
// (RL3) Pattern 000 stops after current frame.
// (RL4) 001 random, 010 zeros, 011 ones.
// (RL5) 100 gives 0x55, 101 counts 255 down.
// (RL6) Continuous mode sends frames without limit.
// (RL7) Burst mode sends programmed count, stops.
// (RL8) 32-bit count reloaded on enable or restart.
// (RL9) Frame is data length plus 18 bytes.
// (RL10) Idle gap of programmed bytes between frames.
// (RL11) Interrupt enable raises interrupt at burst end.
// (RL12) Interrupt forwarded only with mask bit set.
// (RL13) Interrupt status is latched high, readable.
// (RL14) Done flag set at end, read clears.
// (RL15) Restart reloads, clears done, waits frame end.
// (RL16) Reserved bits read zero, ignore writes.
`timescale 1ns/10ps

module tfg_top
  import tfg_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic        diag_clk_en_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic        mac_tx_en_in,
  input  wire logic [7:0]  mac_txd_in,
  output logic             tx_en_out,
  output logic      [7:0]  tx_data_out,
  input  wire logic        irq_mask_in,
  input  wire logic        irq_status_rd_in,
  output logic             irq_latched_out,
  output logic             gen_irq_out
);

  function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] d);
    logic [31:0] c;
    c = crc ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  tfg_cfg_s   cfg_r, cfg_nxt;
  tfg_state_e state_r, state_nxt;
  tfg_tx_s    tx_r, tx_nxt;
  logic [15:0] idx_r, idx_nxt;
  logic [31:0] left_r, left_nxt;
  logic [31:0] crc_r, crc_nxt;
  logic [15:0] lfsr_r, lfsr_nxt;
  logic [15:0] rdata_nxt;
  logic        en_prev_r, pend_r, pend_nxt, run_r, run_nxt;
  logic        done_r, done_nxt, irq_r, irq_nxt, girq_nxt;
  logic        wr_pat, start_req, burst_end, gen_active;
  logic [7:0]  byte_v;
  logic [31:0] fcs_v;

  assign wr_pat     = reg_wr_in && (reg_addr_in == ADDR_PATTERN);
  assign start_req  = (cfg_r.enable && !en_prev_r) || (wr_pat && reg_wdata_in[RESTART_POS]);  // see RL2 see RL8
  assign gen_active = cfg_r.enable && diag_clk_en_in;  // see RL1
  assign fcs_v      = ~crc_r;

  // Register file; the restart bit is never stored, so it reads back as zero.
  always_comb begin
    cfg_nxt   = cfg_r;
    rdata_nxt = 16'h0000;
    if (reg_wr_in) begin
      unique case (reg_addr_in)  // see RL16
        ADDR_ENABLE:  cfg_nxt.enable  = reg_wdata_in[0];
        ADDR_PATTERN: cfg_nxt.pattern = reg_wdata_in[2:0];
        ADDR_CONT:    cfg_nxt.cont    = reg_wdata_in[0];
        ADDR_IRQ_EN:  cfg_nxt.irq_en  = reg_wdata_in[0];
        ADDR_LENGTH:  cfg_nxt.length  = reg_wdata_in;
        ADDR_GAP:     cfg_nxt.gap     = reg_wdata_in;
        ADDR_CNT_HI:  cfg_nxt.cnt_hi  = reg_wdata_in;
        ADDR_CNT_LO:  cfg_nxt.cnt_lo  = reg_wdata_in;
        default:      cfg_nxt         = cfg_r;
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)  // see RL16
        ADDR_ENABLE:  rdata_nxt = {15'h0000, cfg_r.enable};
        ADDR_PATTERN: rdata_nxt = {13'h0000, cfg_r.pattern};
        ADDR_CONT:    rdata_nxt = {15'h0000, cfg_r.cont};
        ADDR_IRQ_EN:  rdata_nxt = {15'h0000, cfg_r.irq_en};
        ADDR_LENGTH:  rdata_nxt = cfg_r.length;
        ADDR_GAP:     rdata_nxt = cfg_r.gap;
        ADDR_CNT_HI:  rdata_nxt = cfg_r.cnt_hi;
        ADDR_CNT_LO:  rdata_nxt = cfg_r.cnt_lo;
        ADDR_DONE:    rdata_nxt = {15'h0000, done_r};
        default:      rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Byte source for header and data positions.
  always_comb begin
    byte_v = 8'h00;
    if (state_r == ST_HDR) begin
      if (idx_r < ADDR_BYTES) begin
        byte_v = DEST_BYTE;
      end else if (idx_r < HDR_BYTES - 16'h0002) begin
        byte_v = SRC_BYTE;
      end else if (idx_r == HDR_BYTES - 16'h0002) begin
        byte_v = cfg_r.length[15:8];
      end else begin
        byte_v = cfg_r.length[7:0];
      end
    end else begin
      unique case (cfg_r.pattern)
        PAT_RANDOM: byte_v = lfsr_r[7:0];  // see RL4
        PAT_ZEROS:  byte_v = 8'h00;  // see RL4
        PAT_ONES:   byte_v = 8'hFF;  // see RL4
        PAT_ALT55:  byte_v = ALT_BYTE;  // see RL5
        PAT_DECR:   byte_v = 8'hFF - idx_r[7:0];  // see RL5
        default:    byte_v = 8'h00;
      endcase
    end
  end

  // Frame sequencer.
  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    left_nxt  = left_r;
    crc_nxt   = crc_r;
    lfsr_nxt  = lfsr_r;
    pend_nxt  = pend_r || start_req;
    run_nxt   = run_r;
    burst_end = 1'b0;
    tx_nxt    = '{en: mac_tx_en_in, data: mac_txd_in};
    if (!gen_active) begin
      state_nxt = ST_IDLE;
      run_nxt   = 1'b0;
    end else begin
      tx_nxt = '{en: 1'b0, data: 8'h00};  // see RL1
      unique case (state_r)
        ST_IDLE, ST_GAP: begin
          if (state_r == ST_GAP && idx_r + 16'h0001 < cfg_r.gap) begin
            idx_nxt = idx_r + 16'h0001;  // see RL10
          end else if (pend_nxt) begin
            pend_nxt  = 1'b0;  // see RL15
            left_nxt  = {cfg_r.cnt_hi, cfg_r.cnt_lo};  // see RL8
            run_nxt   = cfg_r.cont || ({cfg_r.cnt_hi, cfg_r.cnt_lo} != 32'h00000000);
            burst_end = !run_nxt;
            state_nxt = ST_IDLE;
          end else if (run_r && cfg_r.pattern != PAT_STOP) begin  // see RL3
            state_nxt = ST_HDR;
            idx_nxt   = 16'h0000;
            crc_nxt   = CRC_INIT;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
        ST_HDR, ST_DATA: begin
          tx_nxt  = '{en: 1'b1, data: byte_v};
          crc_nxt = crc_byte(crc_r, byte_v);
          idx_nxt = idx_r + 16'h0001;
          if (state_r == ST_DATA) begin
            lfsr_nxt = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
          end
          if (state_r == ST_HDR && idx_r == HDR_BYTES - 16'h0001) begin
            idx_nxt   = 16'h0000;
            state_nxt = (cfg_r.length == 16'h0000) ? ST_FCS : ST_DATA;  // see RL9
          end else if (state_r == ST_DATA && idx_r == cfg_r.length - 16'h0001) begin
            idx_nxt   = 16'h0000;
            state_nxt = ST_FCS;  // see RL9
          end
        end
        ST_FCS: begin
          tx_nxt  = '{en: 1'b1, data: fcs_v[idx_r[1:0]*8 +: 8]};
          idx_nxt = idx_r + 16'h0001;
          if (idx_r == FCS_BYTES - 16'h0001) begin
            idx_nxt   = 16'h0000;
            state_nxt = (cfg_r.gap == 16'h0000) ? ST_IDLE : ST_GAP;
            if (!cfg_r.cont) begin  // see RL6
              left_nxt = left_r - 32'h00000001;  // see RL7
              if (left_r == 32'h00000001) begin
                run_nxt   = 1'b0;
                burst_end = 1'b1;
              end
            end
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
    // A completion in the cycle of the read wins over the read's clear.
    done_nxt = burst_end || (done_r && !(reg_rd_in && reg_addr_in == ADDR_DONE));  // see RL14
    if (start_req && !burst_end) begin
      done_nxt = 1'b0;  // see RL15
    end
    irq_nxt  = (burst_end && cfg_r.irq_en) || (irq_r && !irq_status_rd_in);  // see RL11 see RL13
    girq_nxt = irq_nxt && irq_mask_in;  // see RL12
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cfg_r         <= '{enable: 1'b0, pattern: RST_PATTERN, cont: 1'b0, irq_en: 1'b0, length: RST_LENGTH,
                         gap: RST_GAP, cnt_hi: RST_CNT_HI, cnt_lo: RST_CNT_LO};
      state_r       <= ST_IDLE;
      tx_r          <= '{en: 1'b0, data: 8'h00};
      idx_r         <= 16'h0000;
      left_r        <= 32'h00000000;
      crc_r         <= CRC_INIT;
      lfsr_r        <= LFSR_SEED;
      en_prev_r     <= 1'b0;
      pend_r        <= 1'b0;
      run_r         <= 1'b0;
      done_r        <= 1'b0;
      irq_r         <= 1'b0;
      gen_irq_out   <= 1'b0;
      reg_rdata_out <= 16'h0000;
    end else if (ce_in) begin
      cfg_r         <= cfg_nxt;
      state_r       <= state_nxt;
      tx_r          <= tx_nxt;
      idx_r         <= idx_nxt;
      left_r        <= left_nxt;
      crc_r         <= crc_nxt;
      lfsr_r        <= lfsr_nxt;
      en_prev_r     <= cfg_r.enable;
      pend_r        <= pend_nxt;
      run_r         <= run_nxt;
      done_r        <= done_nxt;
      irq_r         <= irq_nxt;
      gen_irq_out   <= girq_nxt;
      reg_rdata_out <= rdata_nxt;
    end
  end

  assign tx_en_out       = tx_r.en;
  assign tx_data_out     = tx_r.data;
  assign irq_latched_out = irq_r;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  AST_MAC_PASS: assert property (ce_in && !gen_active |=> tx_en_out == $past(mac_tx_en_in))  // see RL1
    else $error("MAC data not passed while generator is off.");
  AST_RESTART_SC: assert property (ce_in && start_req |=> pend_r  // see RL2
    || (state_r == ST_IDLE && $past(gen_active)))
    else $error("Restart request lost.");
  AST_STOP_PAT: assert property (ce_in && state_r == ST_IDLE && cfg_r.pattern == PAT_STOP && !pend_r  // see RL3
    |=> state_r == ST_IDLE)
    else $error("Frame started with stop pattern.");
  AST_ZERO_DATA: assert property (ce_in && gen_active && state_r == ST_DATA && cfg_r.pattern == PAT_ZEROS  // see RL4
    |=> tx_en_out && tx_data_out == 8'h00)
    else $error("Zero pattern byte wrong.");
  AST_DECR_DATA: assert property (ce_in && gen_active && state_r == ST_DATA && cfg_r.pattern == PAT_DECR  // see RL5
    |=> tx_data_out == 8'hFF - $past(idx_r[7:0]))
    else $error("Decrementing pattern byte wrong.");
  AST_CONT_RUN: assert property (cfg_r.cont && run_r && gen_active |-> !burst_end)  // see RL6
    else $error("Continuous mode ended a burst.");
  AST_RELOAD: assert property (ce_in && gen_active && (pend_r || start_req) && state_r == ST_IDLE  // see RL8
    |=> left_r == {$past(cfg_r.cnt_hi), $past(cfg_r.cnt_lo)})
    else $error("Frame count not reloaded.");
  AST_HDR_LEN: assert property (ce_in && gen_active && state_r == ST_HDR && idx_r == 16'h000C  // see RL9
    |=> tx_data_out == $past(cfg_r.length[15:8]))
    else $error("Length field byte wrong.");
  AST_DONE_SET: assert property (ce_in && burst_end |=> done_r)  // see RL14
    else $error("Done flag not set at burst end.");
  AST_IRQ_GATE: assert property ($past(ce_in) && gen_irq_out |-> $past(irq_mask_in))  // see RL12
    else $error("Interrupt forwarded while masked.");
  AST_IRQ_SET: assert property (ce_in && burst_end && cfg_r.irq_en |=> irq_latched_out)  // see RL11
    else $error("Interrupt status not latched.");

  COV_BURST_END: cover property (burst_end && ce_in);
  COV_GAP:       cover property (ce_in && state_r == ST_GAP ##1 state_r == ST_HDR);
  COV_RESTART:   cover property (ce_in && wr_pat && reg_wdata_in[RESTART_POS] && state_r == ST_DATA);

endmodule

/* File: shared/tfg_pkg.sv */
/*
  Package of the test frame generator: register addresses, reset values,
  pattern codes, frame layout constants, state and carrier types.
  Assumes one clock domain and 16-bit register words.
*/
package tfg_pkg;

  localparam logic [15:0] ADDR_ENABLE   = 16'h8020;
  localparam logic [15:0] ADDR_PATTERN  = 16'h8021;
  localparam logic [15:0] ADDR_CONT     = 16'h8022;
  localparam logic [15:0] ADDR_IRQ_EN   = 16'h8023;
  localparam logic [15:0] ADDR_LENGTH   = 16'h8025;
  localparam logic [15:0] ADDR_GAP      = 16'h8026;
  localparam logic [15:0] ADDR_CNT_HI   = 16'h8027;
  localparam logic [15:0] ADDR_CNT_LO   = 16'h8028;
  localparam logic [15:0] ADDR_DONE     = 16'h8029;

  localparam int          RESTART_POS   = 3;
  localparam logic [2:0]  RST_PATTERN   = 3'h1;
  localparam logic [15:0] RST_LENGTH    = 16'h006B;
  localparam logic [15:0] RST_GAP       = 16'h000C;
  localparam logic [15:0] RST_CNT_HI    = 16'h0000;
  localparam logic [15:0] RST_CNT_LO    = 16'h0100;

  localparam logic [2:0]  PAT_STOP      = 3'h0;
  localparam logic [2:0]  PAT_RANDOM    = 3'h1;
  localparam logic [2:0]  PAT_ZEROS     = 3'h2;
  localparam logic [2:0]  PAT_ONES      = 3'h3;
  localparam logic [2:0]  PAT_ALT55     = 3'h4;
  localparam logic [2:0]  PAT_DECR      = 3'h5;

  localparam logic [15:0] ADDR_BYTES    = 16'h0006;
  localparam logic [15:0] HDR_BYTES     = 16'h000E;
  localparam logic [15:0] FCS_BYTES     = 16'h0004;
  localparam logic [7:0]  DEST_BYTE     = 8'hFF;
  localparam logic [7:0]  SRC_BYTE      = 8'h02;
  localparam logic [7:0]  ALT_BYTE      = 8'h55;
  localparam logic [15:0] LFSR_SEED     = 16'hACE1;
  localparam logic [31:0] CRC_INIT      = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY      = 32'hEDB88320;

  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_DATA, ST_FCS, ST_GAP} tfg_state_e;

  typedef struct packed {
    logic        enable;
    logic [2:0]  pattern;
    logic        cont;
    logic        irq_en;
    logic [15:0] length;
    logic [15:0] gap;
    logic [15:0] cnt_hi;
    logic [15:0] cnt_lo;
  } tfg_cfg_s;

  typedef struct packed {
    logic       en;
    logic [7:0] data;
  } tfg_tx_s;

endpackage

/* File: tb/testbench.sv */
/*
  Self-checking bench of the test frame generator.
  Assumes the register strobe port and a PHY model on the tx byte stream.
*/
`timescale 1ns/10ps

module testbench;
  import tfg_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n, wr, rd, mac_en, mask, srd;
  logic [15:0] addr, wdata, rdata, v;
  logic [7:0]  mac_d, tx_d;
  logic        tx_en, irq_l, irq;
  logic        ce, diag;
  int          n_errors = 0;
  int          compares = 0;
  int          f;
  logic [15:0] ra [10] = '{ADDR_ENABLE, ADDR_PATTERN, ADDR_CONT, ADDR_IRQ_EN, 16'h8024, ADDR_LENGTH,
                            ADDR_GAP, ADDR_CNT_HI, ADDR_CNT_LO, ADDR_DONE};
  logic [15:0] rv [10] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h006B,
                            16'h000C, 16'h0000, 16'h0100, 16'h0000};
  logic [2:0]  pat [4] = '{PAT_ZEROS, PAT_ONES, PAT_ALT55, PAT_DECR};
  logic [7:0]  e0 [4]  = '{8'h00, 8'hFF, 8'h55, 8'hFF};
  logic [7:0]  e1 [4]  = '{8'h00, 8'hFF, 8'h55, 8'hFE};

  initial begin
    forever #5 mclk = ~mclk;
  end

  tfg_top dut (.mclk_in(mclk), .rst_n_in(rst_n), .ce_in(ce), .diag_clk_en_in(diag),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .mac_tx_en_in(mac_en), .mac_txd_in(mac_d), .tx_en_out(tx_en), .tx_data_out(tx_d),
    .irq_mask_in(mask), .irq_status_rd_in(srd), .irq_latched_out(irq_l), .gen_irq_out(irq));
  tfg_phy_model phy (.mclk_in(mclk), .tx_en_in(tx_en), .tx_data_in(tx_d));

  task automatic close_out();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
    @(negedge mclk);
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    d = rdata;
    @(negedge mclk);
  endtask

  // Polls the done register under a bound; the read also clears it.
  task automatic wait_done();
    logic [15:0] d;
    for (int i = 0; i < 500; i++) begin
      rd_reg(ADDR_DONE, d);
      if (d === 16'h0001) begin
        repeat (4) @(negedge mclk);
        return;
      end
    end
    n_errors++;
    close_out();
  endtask

  task automatic wait_frames(input int n);
    for (int i = 0; i < 3000; i++) begin
      if (phy.frames >= n) return;
      @(negedge mclk);
    end
    n_errors++;
    close_out();
  endtask

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    mac_en = 1'b0;
    mac_d = 8'h00;
    mask = 1'b1;
    srd = 1'b0;
    ce = 1'b1;
    diag = 1'b1;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd_reg(ra[i], v);
      chk(v, rv[i]);
    end
    wr_reg(ADDR_CONT, 16'hFFFF);
    rd_reg(ADDR_CONT, v);
    chk(v, 16'h0001);
    wr_reg(ADDR_CONT, 16'h0000);
    $display("test registers done");

    mac_en = 1'b1;
    mac_d = 8'hA5;
    repeat (2) @(negedge mclk);
    chk({tx_en, tx_d}, {1'b1, 8'hA5});
    mac_en = 1'b0;
    $display("test mac path done");

    wr_reg(ADDR_LENGTH, 16'h0004);
    wr_reg(ADDR_GAP, 16'h0003);
    wr_reg(ADDR_CNT_LO, 16'h0002);
    wr_reg(ADDR_IRQ_EN, 16'h0001);
    f = phy.frames;
    wr_reg(ADDR_ENABLE, 16'h0001);
    wait_done();
    chk(phy.frames, f + 2);
    chk(phy.len, 22);
    chk(phy.gap, 3);
    chk({irq_l, irq}, 2'b11);
    rd_reg(ADDR_DONE, v);
    chk(v, 16'h0000);
    mask = 1'b0;
    repeat (2) @(negedge mclk);
    chk({irq_l, irq}, 2'b10);
    srd = 1'b1;
    @(negedge mclk);
    srd = 1'b0;
    @(negedge mclk);
    chk(irq_l, 1'b0);
    wr_reg(ADDR_IRQ_EN, 16'h0000);
    wr_reg(ADDR_CNT_LO, 16'h0001);
    $display("test burst done");

    for (int i = 0; i < 4; i++) begin
      f = phy.frames;
      wr_reg(ADDR_PATTERN, {12'h000, 1'b1, pat[i]});
      rd_reg(ADDR_PATTERN, v);
      chk(v, {13'h0000, pat[i]});
      wait_done();
      chk(phy.frames, f + 1);
      chk({phy.b0, phy.b1}, {e0[i], e1[i]});
    end
    chk(irq_l, 1'b0);
    $display("test patterns done");

    wr_reg(ADDR_CONT, 16'h0001);
    wr_reg(ADDR_PATTERN, {12'h000, 1'b1, PAT_ONES});
    f = phy.frames;
    wait_frames(f + 3);
    wr_reg(ADDR_PATTERN, {13'h0000, PAT_STOP});
    repeat (100) @(negedge mclk);
    f = phy.frames;
    repeat (100) @(negedge mclk);
    chk(phy.frames, f);
    chk(phy.len, 22);
    $display("test continuous done");

    // The generator owns the transmit path only while the diagnostic clock is on.
    mac_en = 1'b1;
    mac_d = 8'h5A;
    repeat (2) @(negedge mclk);
    chk({tx_en, tx_d}, {1'b0, 8'h00});
    diag = 1'b0;
    repeat (2) @(negedge mclk);
    chk({tx_en, tx_d}, {1'b1, 8'h5A});
    mac_en = 1'b0;
    diag = 1'b1;
    ce = 1'b0;
    wr_reg(ADDR_GAP, 16'h0007);
    ce = 1'b1;
    rd_reg(ADDR_GAP, v);
    chk(v, 16'h0003);
    $display("test source switch done");
    close_out();
  end
endmodule

/* File: tb/tfg_phy_model.sv */
/*
  Model of the PHY transmit path: counts bytes, frames and idle cycles.
  Assumes one byte per mclk_in cycle while tx_en_in is high.
*/
`timescale 1ns/10ps

module tfg_phy_model (
  input  wire logic       mclk_in,
  input  wire logic       tx_en_in,
  input  wire logic [7:0] tx_data_in
);
  int         frames = 0;
  int         idx    = 0;
  int         len    = 0;
  int         gap    = 0;
  int         idle   = 0;
  logic [7:0] b0     = 8'h00;
  logic [7:0] b1     = 8'h00;

  // The first two data bytes follow the 14 header bytes.
  always @(posedge mclk_in) begin
    if (tx_en_in) begin
      if (idx == 0) gap = idle;
      if (idx == 14) b0 = tx_data_in;
      if (idx == 15) b1 = tx_data_in;
      idx++;
      idle = 0;
    end else begin
      if (idx != 0) begin
        frames++;
        len = idx;
      end
      idx = 0;
      idle++;
    end
  end
endmodule
